// ===== hw/asr_consts.svh
// register offsets, field positions, reset values and timing counts of the receiver
// assumes nothing; included by the fifo, receiver, checker and bench files
`ifndef ASR_CONSTS_SVH
`define ASR_CONSTS_SVH

// ==========================================================
// register offsets (4-bit address)
`define ASR_ADDR_CTRL    4'h0
`define ASR_ADDR_STATUS  4'h1
`define ASR_ADDR_DATA    4'h2
`define ASR_ADDR_BAUD    4'h3

// ==========================================================
// control register fields
`define ASR_CTRL_RXEN    0
`define ASR_CTRL_PTEN    1
`define ASR_CTRL_SYNC    2
`define ASR_CTRL_NINE    3
`define ASR_CTRL_RESET   4'h0

// ==========================================================
// status register fields
`define ASR_STAT_NINTH   0
`define ASR_STAT_OVR     1
`define ASR_STAT_FRAME   2
`define ASR_STAT_PEND    3

// ==========================================================
// timing: oversampling and sample points within a bit
`define ASR_OVERSAMPLE   5'h10
`define ASR_PH_LAST      4'hF
`define ASR_PH_S0        4'h7
`define ASR_PH_S1        4'h8
`define ASR_PH_DECIDE    4'h9
`define ASR_BAUD_RESET   16'h0081

// ==========================================================
// fifo entry layout: {frame error, ninth, data[7:0]}
`define ASR_ENT_W        10
`define ASR_ENT_NINTH    8
`define ASR_ENT_FRAME    9

`endif

// ===== hw/asr_fifo.sv
// two-entry receive fifo, flip-flop storage addressed by index
// assumes push is never issued while full unless pop is issued too
`timescale 1ns/1ps
`default_nettype none
`include "asr_consts.svh"

module asr_fifo (
  input  wire logic                     clk_in,
  input  wire logic                     rst_in,
  input  wire logic                     flush_in,
  input  wire logic                     push_in,
  input  wire logic [`ASR_ENT_W-1:0]    push_data_in,
  input  wire logic                     pop_in,
  output logic      [`ASR_ENT_W-1:0]    head_out,
  output logic                          empty_out,
  output logic                          full_out
);

  logic [`ASR_ENT_W-1:0] mem_q [2];
  logic [`ASR_ENT_W-1:0] mem_d [2];
  logic                  rd_q;
  logic                  rd_d;
  logic [1:0]            cnt_q;
  logic [1:0]            cnt_d;
  logic                  do_pop;
  logic                  do_push;
  logic                  wr_idx;

  // ==========================================================
  // pointer and count update; pop frees room for a same-cycle push
  always_comb begin
    do_pop  = pop_in && (cnt_q != 2'h0);
    do_push = push_in && ((cnt_q != 2'h2) || do_pop);
    wr_idx  = rd_q ^ cnt_q[0]; // full with pop reuses the slot being freed
    mem_d   = mem_q;
    rd_d    = rd_q ^ do_pop;
    cnt_d   = cnt_q + {1'b0, do_push} - {1'b0, do_pop};
    if (do_push) begin
      mem_d[wr_idx] = push_data_in;
    end
    if (flush_in) begin
      rd_d  = 1'b0;
      cnt_d = 2'h0;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      rd_q     <= 1'b0;
      cnt_q    <= 2'h0;
    end else begin
      mem_q <= mem_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  assign head_out  = (cnt_q == 2'h0) ? '0 : mem_q[rd_q]; // oldest entry
  assign empty_out = (cnt_q == 2'h0);
  assign full_out  = (cnt_q == 2'h2);

endmodule // asr_fifo

`default_nettype wire

// ===== hw/asr_pkg.sv
// types shared by the receiver files
// assumes nothing; the state encodings are written out here, not taken from asr_consts.svh
package asr_pkg;

  // ==========================================================
  // recovery state machine, one-hot
  typedef enum logic [3:0] {
    ASR_ST_IDLE  = 4'h1,
    ASR_ST_START = 4'h2,
    ASR_ST_DATA  = 4'h4,
    ASR_ST_STOP  = 4'h8
  } asr_state_t;

endpackage

// ===== hw/asr_rx.sv
// asynchronous serial receiver: 16x data recovery, shift register, fifo, registers
// assumes line and register port are synchronous to clk_in (20 MHz)
//
// Notes on behaviour
// RULE1 - recovery samples at sixteen times baud; shift register moves once per bit
// RULE2 - finished character moves into the two-entry fifo at once
// RULE3 - two characters held while a third is still being received
// RULE4 - shift register and fifo reachable only through the data register
// RULE5 - reception only with receive enable 1, clocked mode 0, port enable 1
// RULE6 - software sets the serial pin as an input beforehand
// RULE7 - software clears the pin's analog select before reception
// RULE8 - falling edge of the line starts a character with its start bit
// RULE9 - start rechecked at half bit; high means silent abort and rearm
// RULE10 - each data bit taken at its centre, one bit apart, by majority
// RULE11 - stop bit sampled one bit later; low sets framing error
// RULE12 - after stop bit character enters fifo and pending flag rises
// RULE13 - reading data register returns oldest character and removes it
// RULE14 - after overrun no more characters accepted until cleared
// RULE15 - overrun on third whole character; cleared by either enable going low
// RULE16 - framing error stored per entry; port enable low clears it
// RULE17 - nine-bit select shifts nine bits; ninth bit shown in status
// RULE18 - pending flag read-only, set while enabled and fifo not empty
// RULE19 - data arrives least significant bit first
// RULE20 - majority of three 16x samples around bit centre
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "asr_consts.svh"

module asr_rx (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        serial_in_pin_in,
  input  wire logic [3:0]  addr_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [15:0] rdata_out,
  output logic             rx_pending_flag_out
);

  // ==========================================================
  // declarations
  asr_pkg::asr_state_t   state_q;
  asr_pkg::asr_state_t   state_d;
  logic [3:0]            phase_q;
  logic [3:0]            phase_d;
  logic [3:0]            bitcnt_q;
  logic [3:0]            bitcnt_d;
  logic [1:0]            samp_q;
  logic [1:0]            samp_d;
  logic                  prev_q;
  logic                  prev_d;
  logic [8:0]            rx_shift_register_q;
  logic [8:0]            rx_shift_register_d;
  logic                  overrun_flag_q;
  logic                  overrun_flag_d;
  logic [3:0]            ctrl_q;
  logic [3:0]            ctrl_d;
  logic [15:0]           baud_q;
  logic [15:0]           baud_d;
  logic [15:0]           rdata_q;
  logic [15:0]           rdata_d;
  logic                  tick;
  logic                  rx_on;
  logic                  maj;
  logic                  nbits_done;
  logic                  push;
  logic                  pop;
  logic [`ASR_ENT_W-1:0] push_data;
  logic [`ASR_ENT_W-1:0] head;
  logic                  fifo_empty;
  logic                  fifo_full;
  logic [3:0]            nbits;
  logic [7:0]            char_data;
  logic                  char_ninth;
  logic                  char_frame_err;
  logic [15:0]           status_word;

  // ==========================================================
  // control decode
  assign rx_on = ctrl_q[`ASR_CTRL_RXEN] && ctrl_q[`ASR_CTRL_PTEN]
                 && !ctrl_q[`ASR_CTRL_SYNC]; // RULE5
  assign nbits = ctrl_q[`ASR_CTRL_NINE] ? 4'h9 : 4'h8; // RULE17

  // ==========================================================
  // 16x oversampling enable from the baud divisor
  asr_tick_div #(
    .W (16)
  ) u_tick (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .run_in   (rx_on),
    .div_in   (baud_q),
    .tick_out (tick)
  );

  // ==========================================================
  // receive fifo; port enable low empties it and its error bits
  asr_fifo u_fifo (
    .clk_in       (clk_in),
    .rst_in       (rst_in),
    .flush_in     (!ctrl_q[`ASR_CTRL_PTEN]), // RULE16
    .push_in      (push),
    .push_data_in (push_data),
    .pop_in       (pop),
    .head_out     (head),
    .empty_out    (fifo_empty),
    .full_out     (fifo_full)
  );

  // ==========================================================
  // majority of samples 7, 8 and the live one at 9
  assign maj = (samp_q[0] & samp_q[1]) | (samp_q[0] & serial_in_pin_in)
               | (samp_q[1] & serial_in_pin_in); // RULE20

  // last data bit about to be taken
  assign nbits_done = (bitcnt_q == nbits - 4'h1);

  // ==========================================================
  // align the shifted bits: first bit received is bit 0
  always_comb begin
    if (ctrl_q[`ASR_CTRL_NINE]) begin
      char_data  = rx_shift_register_q[7:0]; // RULE19
      char_ninth = rx_shift_register_q[8]; // RULE17
    end else begin
      char_data  = rx_shift_register_q[8:1]; // RULE19
      char_ninth = 1'b0;
    end
  end

  // ==========================================================
  // data recovery state machine
  always_comb begin
    state_d             = state_q;
    phase_d             = phase_q;
    bitcnt_d            = bitcnt_q;
    samp_d              = samp_q;
    prev_d              = prev_q;
    rx_shift_register_d = rx_shift_register_q;
    overrun_flag_d      = overrun_flag_q;
    push                = 1'b0;
    char_frame_err      = 1'b0;
    push_data           = '0;
    if (tick) begin
      prev_d  = serial_in_pin_in;
      phase_d = phase_q + 4'h1; // RULE1
      if (phase_q == `ASR_PH_S0) begin
        samp_d[0] = serial_in_pin_in;
      end
      if (phase_q == `ASR_PH_S1) begin
        samp_d[1] = serial_in_pin_in;
      end
    end
    case (state_q)
      asr_pkg::ASR_ST_IDLE: begin
        phase_d  = 4'h0;
        bitcnt_d = 4'h0;
        // a falling edge seen on the 16x grid opens a character, even with the fifo full
        if (tick && prev_q && !serial_in_pin_in && !overrun_flag_q) begin // RULE14 RULE3
          state_d = asr_pkg::ASR_ST_START; // RULE8
          phase_d = 4'h1;
        end
      end
      asr_pkg::ASR_ST_START: begin
        if (tick && phase_q == `ASR_PH_DECIDE) begin
          if (maj) begin
            state_d = asr_pkg::ASR_ST_IDLE; // RULE9
          end else begin
            state_d = asr_pkg::ASR_ST_DATA; // RULE10
          end
        end
      end
      asr_pkg::ASR_ST_DATA: begin
        // sample one full bit after the previous centre
        if (tick && phase_q == `ASR_PH_DECIDE) begin
          rx_shift_register_d = {maj, rx_shift_register_q[8:1]}; // RULE10
          bitcnt_d            = bitcnt_q + 4'h1;
          if (nbits_done) begin
            state_d = asr_pkg::ASR_ST_STOP;
          end
        end
      end
      asr_pkg::ASR_ST_STOP: begin
        if (tick && phase_q == `ASR_PH_DECIDE) begin
          state_d        = asr_pkg::ASR_ST_IDLE;
          char_frame_err = !maj; // RULE11
          push_data      = {char_frame_err, char_ninth, char_data};
          // third whole character with no room: raise overrun, drop it
          if (fifo_full && !pop) begin
            overrun_flag_d = 1'b1; // RULE15
          end else begin
            push = 1'b1; // RULE2 RULE12
          end
        end
      end
      default: begin
        state_d = asr_pkg::ASR_ST_IDLE;
      end
    endcase
    // receiver off: abandon any character in progress
    if (!rx_on) begin
      state_d = asr_pkg::ASR_ST_IDLE; // RULE5
      prev_d  = 1'b0;
      phase_d = 4'h0;
    end
    // either enable low clears the overrun
    if (!ctrl_q[`ASR_CTRL_RXEN] || !ctrl_q[`ASR_CTRL_PTEN]) begin
      overrun_flag_d = 1'b0; // RULE15
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q             <= asr_pkg::ASR_ST_IDLE;
      phase_q             <= 4'h0;
      bitcnt_q            <= 4'h0;
      samp_q              <= 2'h3;
      prev_q              <= 1'b0;
      rx_shift_register_q <= 9'h000;
      overrun_flag_q      <= 1'b0;
    end else begin
      state_q             <= state_d;
      phase_q             <= phase_d;
      bitcnt_q            <= bitcnt_d;
      samp_q              <= samp_d;
      prev_q              <= prev_d;
      rx_shift_register_q <= rx_shift_register_d;
      overrun_flag_q      <= overrun_flag_d;
    end
  end

  // ==========================================================
  // pending flag and status view of the oldest entry
  assign rx_pending_flag_out = rx_on && !fifo_empty; // RULE18

  always_comb begin
    status_word                 = 16'h0000;
    status_word[`ASR_STAT_NINTH] = head[`ASR_ENT_NINTH]; // RULE17
    status_word[`ASR_STAT_OVR]   = overrun_flag_q;
    status_word[`ASR_STAT_FRAME] = head[`ASR_ENT_FRAME]; // RULE16
    status_word[`ASR_STAT_PEND]  = rx_pending_flag_out; // RULE18
  end

  // ==========================================================
  // register port: writes, reads with one-cycle latency, data pop
  always_comb begin
    ctrl_d  = ctrl_q;
    baud_d  = baud_q;
    rdata_d = 16'h0000;
    pop     = 1'b0;
    if (wr_in) begin
      case (addr_in)
        `ASR_ADDR_CTRL: begin
          ctrl_d = wdata_in[3:0];
        end
        `ASR_ADDR_BAUD: begin
          baud_d = wdata_in;
        end
        default: begin
          ctrl_d = ctrl_q; // status, data and unmapped ignore writes
        end
      endcase
    end
    if (rd_in) begin
      case (addr_in)
        `ASR_ADDR_CTRL: begin
          rdata_d = {12'h000, ctrl_q};
        end
        `ASR_ADDR_STATUS: begin
          rdata_d = status_word;
        end
        `ASR_ADDR_DATA: begin
          // only path to received data; reading removes the oldest
          rdata_d = {8'h00, head[7:0]}; // RULE4 RULE13
          pop     = !fifo_empty; // RULE13
        end
        `ASR_ADDR_BAUD: begin
          rdata_d = baud_q;
        end
        default: begin
          rdata_d = 16'h0000; // unmapped reads zero
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_q  <= `ASR_CTRL_RESET;
      baud_q  <= `ASR_BAUD_RESET;
      rdata_q <= 16'h0000;
    end else begin
      ctrl_q  <= ctrl_d;
      baud_q  <= baud_d;
      rdata_q <= rdata_d;
    end
  end

  assign rdata_out = rdata_q; // valid the cycle after rd_in

endmodule // asr_rx

`default_nettype wire

// ===== hw/asr_tick_div.sv
// divider producing the 16x oversampling enable pulse
// assumes the divisor is held stable by software while running
`timescale 1ns/1ps
`default_nettype none

module asr_tick_div #(
  parameter int unsigned W = 16
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic         run_in,
  input  wire logic [W-1:0] div_in,
  output logic              tick_out
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  // ==========================================================
  // count 0..div, pulse on the wrap
  always_comb begin
    cnt_d = cnt_q + {{(W-1){1'b0}}, 1'b1};
    if (!run_in || cnt_q >= div_in) begin
      cnt_d = '0;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign tick_out = run_in && (cnt_q >= div_in); // one clock wide every div_in + 1 clocks; high on every clock when div_in is 0

endmodule // asr_tick_div

`default_nettype wire

// ===== tb/asr_line_model.sv
// remote transmitter model driving the serial line
// assumes the bench sets bit_clks to sixteen times (divisor + 1)
`timescale 1ns/1ps
`default_nettype none

module asr_line_model (
  input  wire logic clk_in,
  output logic      line_out
);
  int bit_clks = 16;
  // line idles high between frames
  initial line_out = 1'b1;

  // ======
  // one frame: start, data lsb first, stop; glitch flips one mid-bit clock of each data bit
  task automatic send(input logic [8:0] d, input int n, input logic stop, input logic glitch);
    int i;
    int k;
    for (i = -1; i <= n; i++) begin
      for (k = 0; k < bit_clks; k++) begin
        @(posedge clk_in);
        if (i < 0) line_out <= 1'b0;
        else if (i == n) line_out <= stop;
        else line_out <= d[i] ^ (glitch && k == bit_clks / 2 + 1);
      end
    end
    @(posedge clk_in);
    line_out <= 1'b1;
  endtask

  // short low pulse that is not a start bit
  task automatic pulse_low(input int n);
    repeat (n) begin
      @(posedge clk_in);
      line_out <= 1'b0;
    end
    @(posedge clk_in);
    line_out <= 1'b1;
  endtask
endmodule // asr_line_model
`default_nettype wire

// ===== tb/asr_rx_sva.sv
// checker for the receiver: register answers and the pending flag
// assumes it is bound to asr_rx and sees its ports only
`timescale 1ns/1ps
`default_nettype none
`include "asr_consts.svh"

module asr_rx_sva (
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        serial_in_pin_in,
  input wire logic [3:0]  addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [15:0] rdata_out,
  input wire logic        rx_pending_flag_out
);
  // ======
  // shadow of the writable registers
  logic [3:0]  ctrl_q;
  logic [3:0]  ctrl_d;
  logic [15:0] baud_q;
  logic [15:0] baud_d;
  logic        rx_on;
  // next shadow values from register writes
  always_comb begin
    ctrl_d = ctrl_q;
    baud_d = baud_q;
    if (wr_in && addr_in == `ASR_ADDR_CTRL) begin
      ctrl_d = wdata_in[3:0];
    end
    if (wr_in && addr_in == `ASR_ADDR_BAUD) begin
      baud_d = wdata_in;
    end
  end
  // shadow registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_q <= `ASR_CTRL_RESET;
      baud_q <= `ASR_BAUD_RESET;
    end else begin
      ctrl_q <= ctrl_d;
      baud_q <= baud_d;
    end
  end
  // receiver fully enabled
  assign rx_on = ctrl_q[0] && ctrl_q[1] && !ctrl_q[2];

  // ======
  // assertions
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  rdata_quiet_a: assert property (!$past(rd_in) |-> rdata_out == 16'h0000)
    else $error("read data not zero outside a read answer");
  ctrl_read_a: assert property (rd_in && addr_in == `ASR_ADDR_CTRL |=>
    rdata_out == {12'h000, $past(ctrl_q)}) else $error("control readback wrong");
  baud_read_a: assert property (rd_in && addr_in == `ASR_ADDR_BAUD |=>
    rdata_out == $past(baud_q)) else $error("divisor readback wrong");
  empty_read_a: assert property (rd_in && addr_in == `ASR_ADDR_DATA && rx_on
    && !rx_pending_flag_out |=> rdata_out == 16'h0000) else $error("empty read not zero");
  pend_drop_a: assert property ($fell(rx_pending_flag_out) |->
    $past(rd_in && addr_in == `ASR_ADDR_DATA) || $past(wr_in && addr_in == `ASR_ADDR_CTRL))
    else $error("pending fell without read or control write");
  stat_pend_a: assert property (rd_in && addr_in == `ASR_ADDR_STATUS |=>
    rdata_out[3] == $past(rx_pending_flag_out) && rdata_out[15:4] == 12'h000)
    else $error("status pending bit wrong");
  off_quiet_a: assert property (wr_in && addr_in == `ASR_ADDR_CTRL &&
    !(wdata_in[0] && wdata_in[1] && !wdata_in[2]) |=> !rx_pending_flag_out [*2])
    else $error("pending while receiver off");
  data_width_a: assert property (rd_in && addr_in == `ASR_ADDR_DATA |=>
    rdata_out[15:8] == 8'h00) else $error("data read wider than eight bits");
endmodule // asr_rx_sva

bind asr_rx asr_rx_sva u_sva (.clk_in(clk_in), .rst_in(rst_in),
  .serial_in_pin_in(serial_in_pin_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .rx_pending_flag_out(rx_pending_flag_out));
`default_nettype wire

// ===== tb/asr_rx_tb_top.sv
// self-checking bench for the asynchronous receiver
// assumes the line model and the bound checker are compiled alongside
`timescale 1ns/1ps
`default_nettype none
`include "asr_consts.svh"

module asr_rx_tb_top;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        line;
  logic [3:0]  addr_in = 4'h0;
  logic [15:0] wdata_in = 16'h0000;
  logic        wr_in = 1'b0;
  logic        rd_in = 1'b0;
  logic [15:0] rdata_out;
  logic        rx_pending_flag_out;
  int          error_cnt = 0;
  int          compares = 0;

  // 20 MHz clock
  always #25 clk_in = ~clk_in;

  asr_rx u_dut (.clk_in(clk_in), .rst_in(rst_in), .serial_in_pin_in(line),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .rx_pending_flag_out(rx_pending_flag_out));
  asr_line_model u_tx (.clk_in(clk_in), .line_out(line));

  // ======
  // compare, bus and wait helpers
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 chk(rdata_out, exp);
  endtask
  task automatic wait_pend();
    int n;
    n = 0;
    while (rx_pending_flag_out !== 1'b1 && n < 400) begin
      @(posedge clk_in);
      n++;
    end
    chk({15'h0000, rx_pending_flag_out}, 16'h0001);
  endtask

  // ======
  // scenarios
  task automatic t_reset();
    rchk(`ASR_ADDR_CTRL, 16'h0000);
    rchk(`ASR_ADDR_BAUD, 16'h0081);
    wr(`ASR_ADDR_STATUS, 16'hFFFF);
    rchk(`ASR_ADDR_STATUS, 16'h0000);
    rchk(4'h7, 16'h0000);
    wr(`ASR_ADDR_BAUD, 16'h0000);
    wr(`ASR_ADDR_CTRL, 16'h0003);
  endtask
  task automatic t_basic();
    u_tx.send(9'h0A5, 8, 1'b1, 1'b0);
    u_tx.send(9'h05A, 8, 1'b1, 1'b1);
    wait_pend();
    rchk(`ASR_ADDR_STATUS, 16'h0008);
    rchk(`ASR_ADDR_DATA, 16'h00A5);
    rchk(`ASR_ADDR_DATA, 16'h005A);
    chk({15'h0000, rx_pending_flag_out}, 16'h0000);
  endtask
  task automatic t_slow();
    wr(`ASR_ADDR_BAUD, 16'h0001);
    u_tx.bit_clks = 32;
    u_tx.send(9'h03A, 8, 1'b1, 1'b1);
    wait_pend();
    rchk(`ASR_ADDR_DATA, 16'h003A);
    wr(`ASR_ADDR_BAUD, 16'h0000);
    u_tx.bit_clks = 16;
  endtask
  task automatic t_overrun();
    u_tx.send(9'h011, 8, 1'b1, 1'b0);
    u_tx.send(9'h022, 8, 1'b1, 1'b0);
    u_tx.send(9'h033, 8, 1'b1, 1'b0);
    rchk(`ASR_ADDR_STATUS, 16'h000A);
    rchk(`ASR_ADDR_DATA, 16'h0011);
    rchk(`ASR_ADDR_DATA, 16'h0022);
    rchk(`ASR_ADDR_DATA, 16'h0000);
    u_tx.send(9'h044, 8, 1'b1, 1'b0);
    rchk(`ASR_ADDR_STATUS, 16'h0002);
    wr(`ASR_ADDR_CTRL, 16'h0002);
    wr(`ASR_ADDR_CTRL, 16'h0003);
    rchk(`ASR_ADDR_STATUS, 16'h0000);
    u_tx.send(9'h055, 8, 1'b1, 1'b0);
    wait_pend();
    rchk(`ASR_ADDR_DATA, 16'h0055);
  endtask
  task automatic t_frame();
    u_tx.send(9'h03C, 8, 1'b0, 1'b0);
    wait_pend();
    rchk(`ASR_ADDR_STATUS, 16'h000C);
    wr(`ASR_ADDR_CTRL, 16'h0002);
    rchk(`ASR_ADDR_STATUS, 16'h0004);
    wr(`ASR_ADDR_CTRL, 16'h0000);
    rchk(`ASR_ADDR_STATUS, 16'h0000);
    wr(`ASR_ADDR_CTRL, 16'h0003);
    rchk(`ASR_ADDR_DATA, 16'h0000);
  endtask
  task automatic t_nine();
    wr(`ASR_ADDR_CTRL, 16'h000B);
    u_tx.send(9'h1C3, 9, 1'b1, 1'b0);
    wait_pend();
    rchk(`ASR_ADDR_STATUS, 16'h0009);
    rchk(`ASR_ADDR_DATA, 16'h00C3);
    wr(`ASR_ADDR_CTRL, 16'h0003);
  endtask
  task automatic t_false();
    u_tx.pulse_low(4);
    repeat (200) @(posedge clk_in);
    rchk(`ASR_ADDR_STATUS, 16'h0000);
    u_tx.send(9'h096, 8, 1'b1, 1'b0);
    wait_pend();
    rchk(`ASR_ADDR_DATA, 16'h0096);
  endtask
  task automatic t_off();
    logic [15:0] c[3] = '{16'h0007, 16'h0002, 16'h0001};
    foreach (c[i]) begin
      wr(`ASR_ADDR_CTRL, c[i]);
      u_tx.send(9'h077, 8, 1'b1, 1'b0);
      rchk(`ASR_ADDR_STATUS, 16'h0000);
      wr(`ASR_ADDR_CTRL, 16'h0003);
      rchk(`ASR_ADDR_DATA, 16'h0000);
    end
  endtask

  // ======
  // verdict and run control
  task automatic results();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // main sequence after two reset cycles
  initial begin
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_basic();
    t_slow();
    t_overrun();
    t_frame();
    t_nine();
    t_false();
    t_off();
    results();
  end
  // watchdog, about seven times the expected run
  initial begin
    #1000000;
    error_cnt++;
    results();
  end
endmodule // asr_rx_tb_top
`default_nettype wire
